// >>> src/anp_autoneg_ctl.sv
/*
  Auto-negotiation remote fault, restart and progress monitor logic
  with a classic Wishbone register slave.
  Assumes the arbitration state machine, link monitor and code word
  receiver run on ref_clk; the mode and select pins are asynchronous.
*/
// The register offsets and the Wishbone register port were chosen for this implementation.
// Functional notes
// - Partner remote fault sets fault bits in basic, partner and quick status.
// - Partner fault during capability exchange also sets extended control fault bit.
// - Local link fault advertises fault and sets partner and extended fault bits.
// - When enabled, negotiation starts after power-up and on management request.
// - Any reset idles arbitration and monitor and clears progress bits.
// - Restart reinitialises arbitration and monitor but keeps progress bits.
// - After restart progress bits change only on read, reset or higher state.
// - After completion progress bits change only on quick status read or reset.
// - Link failure restarts negotiation in either configuration mode.
// - Software mode: writing restart bit restarts; the bit clears itself.
// - Software mode: enable bit toggled one-zero-one restarts negotiation.
// - Hardware mode: select pin toggled high-low-high restarts negotiation.
// - Quick status reports speed, duplex, link status and negotiation complete.
// - Progress code is complete bit above quick status bits thirteen to eleven.
// - Progress code takes values zero through eight or all ones.
// - Between reads progress bits load only a higher arbitration state.
// - Reading progress bits loads the present state unconditionally.
// - A read returns the value held before that read.
// - First read after completion returns complete and progress bits all ones.
// - Later reads with link up return complete and progress bits zero.
// - Completion sets negotiation complete in basic and quick status.
`timescale 1ns/1ps

module anp_autoneg_ctl (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic      [31:0] wb_dat_o,
  // Configuration pins
  input  wire logic        mode_pin_a,
  input  wire logic        autoneg_select_pin,
  // Arbitration and link status
  input  wire logic [3:0]  arb_state,
  input  wire logic        an_complete,
  input  wire logic        link_up,
  input  wire logic        speed_100,
  input  wire logic        full_duplex,
  // Fault sources
  input  wire logic        partner_rf,
  input  wire logic        exchange_active,
  input  wire logic        local_link_fault,
  // Arbitration control and advertisement
  output logic             an_enable,
  output logic             an_restart,
  output logic             adv_remote_fault
);

  // Bus decode
  logic        req;
  logic        rd_req;
  logic        wr_req;
  logic [5:0]  idx;
  logic        qst_read;

  // Pin synchronisers
  logic        mode_s1_reg;
  logic        mode_s2_reg;
  logic        sel_s1_reg;
  logic        sel_s2_reg;
  logic        sel_s3_reg;

  // Control state
  logic        ctl_en_reg;
  logic        ctl_en_prev_reg;
  logic        restart_bit_reg;
  logic        srst_reg;
  logic        pwrup_reg;
  logic [1:0]  settle_reg;
  logic        link_prev_reg;
  logic        restart_next;
  logic        en_eff;

  // Fault and progress state
  logic        bst_rf_reg;
  logic        lpa_rf_reg;
  logic        qst_rf_reg;
  logic        ext_rf_reg;
  logic [3:0]  prog_reg;
  logic        done_seen_reg;
  logic        done_rpt_reg;
  logic [31:0] rd_data;

  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign rd_req   = req & ~wb_we_i;
  assign wr_req   = req & wb_we_i & wb_sel_i[1];
  assign idx      = wb_adr_i[7:2];
  assign qst_read = rd_req && idx == anp_pkg::REG_QST_IDX;

  // Only the second mode stage and the second and third select stages are read; the first may be metastable
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode_s1_reg <= 1'b0;
      mode_s2_reg <= 1'b0;
      sel_s1_reg  <= 1'b0;
      sel_s2_reg  <= 1'b0;
      sel_s3_reg  <= 1'b0;
    end else begin
      mode_s1_reg <= mode_pin_a;
      mode_s2_reg <= mode_s1_reg;
      sel_s1_reg  <= autoneg_select_pin;
      sel_s2_reg  <= sel_s1_reg;
      sel_s3_reg  <= sel_s2_reg;
    end
  end

  assign en_eff = mode_s2_reg ? ctl_en_reg : sel_s2_reg;

  // Restart sources, merged into one pulse towards arbitration
  always_comb begin
    restart_next = 1'b0;
    if (en_eff) begin
      if (pwrup_reg || srst_reg)
        restart_next = 1'b1;
      if (link_prev_reg && !link_up)
        restart_next = 1'b1;
      if (mode_s2_reg && restart_bit_reg)
        restart_next = 1'b1;
      if (mode_s2_reg && ctl_en_reg && !ctl_en_prev_reg)
        restart_next = 1'b1;
      if (!mode_s2_reg && sel_s2_reg && !sel_s3_reg)
        restart_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      an_restart    <= 1'b0;
      an_enable     <= 1'b0;
      settle_reg    <= 2'b00;
      pwrup_reg     <= 1'b0;
      link_prev_reg <= 1'b0;
    end else begin
      an_restart    <= restart_next;
      an_enable     <= en_eff;
      // Power-up attempt waits until the pin synchronisers hold real values
      settle_reg    <= {settle_reg[0], 1'b1};
      pwrup_reg     <= settle_reg == 2'b01;
      link_prev_reg <= link_up;
    end
  end

  // Control register; restart and soft reset bits clear themselves
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_en_reg      <= anp_pkg::CTL_AN_EN_RST;
      ctl_en_prev_reg <= anp_pkg::CTL_AN_EN_RST;
      restart_bit_reg <= 1'b0;
      srst_reg        <= 1'b0;
    end else begin
      ctl_en_prev_reg <= ctl_en_reg;
      srst_reg        <= 1'b0;
      if (restart_bit_reg)
        restart_bit_reg <= 1'b0;
      if (wr_req && idx == anp_pkg::REG_CTL_IDX) begin
        ctl_en_reg <= wb_dat_i[anp_pkg::CTL_AN_EN_BIT];
        srst_reg   <= wb_dat_i[anp_pkg::CTL_SRST_BIT];
        if (wb_dat_i[anp_pkg::CTL_RESTART_BIT])
          restart_bit_reg <= 1'b1;
      end
    end
  end

  // Fault bits latch high; a read clears them but a new event wins
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bst_rf_reg       <= 1'b0;
      lpa_rf_reg       <= 1'b0;
      qst_rf_reg       <= 1'b0;
      ext_rf_reg       <= 1'b0;
      adv_remote_fault <= 1'b0;
    end else begin
      adv_remote_fault <= local_link_fault;
      if (rd_req && idx == anp_pkg::REG_BST_IDX)
        bst_rf_reg <= 1'b0;
      if (rd_req && idx == anp_pkg::REG_LPA_IDX)
        lpa_rf_reg <= 1'b0;
      if (qst_read)
        qst_rf_reg <= 1'b0;
      if (rd_req && idx == anp_pkg::REG_EXT_IDX)
        ext_rf_reg <= 1'b0;
      if (partner_rf) begin
        bst_rf_reg <= 1'b1;
        lpa_rf_reg <= 1'b1;
        qst_rf_reg <= 1'b1;
      end
      if (partner_rf && exchange_active)
        ext_rf_reg <= 1'b1;
      if (local_link_fault) begin
        lpa_rf_reg <= 1'b1;
        ext_rf_reg <= 1'b1;
      end
    end
  end

  // Progress monitor; a restart leaves the held code alone
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prog_reg      <= anp_pkg::PROG_RST;
      done_seen_reg <= 1'b0;
    end else if (srst_reg) begin
      prog_reg      <= anp_pkg::PROG_RST;
      done_seen_reg <= 1'b0;
    end else begin
      if (qst_read)
        prog_reg <= arb_state;
      else if (!done_seen_reg && arb_state > prog_reg)
        prog_reg <= arb_state;
      if (an_restart)
        done_seen_reg <= 1'b0;
      else if (arb_state == anp_pkg::PROG_DONE)
        done_seen_reg <= 1'b1;
    end
  end

  // Completion already reported once; later reads show a zero code while link holds
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      done_rpt_reg <= 1'b0;
    else if (srst_reg)
      done_rpt_reg <= 1'b0;
    else if (qst_read)
      done_rpt_reg <= link_up && prog_reg == anp_pkg::PROG_DONE
                      && arb_state == anp_pkg::PROG_DONE;
    else if (an_restart || !link_up || arb_state != anp_pkg::PROG_DONE)
      done_rpt_reg <= 1'b0;
  end

  // Read mux; the quick status shows the code held before this read
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (idx)
      anp_pkg::REG_CTL_IDX: begin
        rd_data[anp_pkg::CTL_AN_EN_BIT]   = ctl_en_reg;
        rd_data[anp_pkg::CTL_RESTART_BIT] = restart_bit_reg;
      end
      anp_pkg::REG_BST_IDX: begin
        rd_data[anp_pkg::BST_AN_DONE_BIT] = an_complete;
        rd_data[anp_pkg::BST_RF_BIT]      = bst_rf_reg;
        rd_data[anp_pkg::BST_LINK_BIT]    = link_up;
      end
      anp_pkg::REG_LPA_IDX: begin
        rd_data[anp_pkg::LPA_RF_BIT] = lpa_rf_reg;
      end
      anp_pkg::REG_QST_IDX: begin
        rd_data[anp_pkg::QST_SPEED_BIT]  = speed_100;
        rd_data[anp_pkg::QST_DUPLEX_BIT] = full_duplex;
        rd_data[anp_pkg::QST_PROG_HI:anp_pkg::QST_PROG_LO] =
          done_rpt_reg ? 3'h0 : prog_reg[2:0];
        rd_data[anp_pkg::QST_AN_BIT]     = prog_reg[3];
        rd_data[anp_pkg::QST_RF_BIT]     = qst_rf_reg;
        rd_data[anp_pkg::QST_LINK_BIT]   = link_up;
      end
      anp_pkg::REG_EXT_IDX: begin
        rd_data[anp_pkg::EXT_RF_BIT] = ext_rf_reg;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // One wait state; ack falls in the cycle after it rose
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (rd_req)
        wb_dat_o <= rd_data;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence qst_rd_s;
    qst_read ##1 wb_ack_o;
  endsequence

  prog_read_old_a: assert property (
    qst_read |=> wb_dat_o[anp_pkg::QST_PROG_HI:anp_pkg::QST_PROG_LO]
      == $past(done_rpt_reg ? 3'h0 : prog_reg[2:0])
  ) else $error("Read did not return the held progress code");

  prog_read_load_a: assert property (
    qst_read && !srst_reg |=> prog_reg == $past(arb_state)
  ) else $error("Read did not load the present state");

  prog_monotone_a: assert property (
    !qst_read && !srst_reg && prog_reg < anp_pkg::PROG_DONE && arb_state < prog_reg
      |=> prog_reg == $past(prog_reg)
  ) else $error("Progress code fell without a read");

  prog_done_hold_a: assert property (
    done_seen_reg && !qst_read && !srst_reg |=> $stable(prog_reg)
  ) else $error("Progress code changed after completion without a read");

  prog_code_legal_a: assert property (
    prog_reg <= anp_pkg::PROG_MAX_NUM || prog_reg == anp_pkg::PROG_DONE
  ) else $error("Progress code outside legal set");

  restart_keep_a: assert property (
    an_restart && !qst_read && !srst_reg && arb_state <= prog_reg |=> $stable(prog_reg)
  ) else $error("Restart disturbed the progress code");

  sw_restart_a: assert property (
    mode_s2_reg && ctl_en_reg && restart_bit_reg |=> an_restart ##1 !restart_bit_reg
  ) else $error("Restart bit did not restart and clear");

  link_fail_a: assert property (
    en_eff && link_prev_reg && !link_up |=> an_restart
  ) else $error("Link failure did not restart");

  hw_sel_a: assert property (
    !mode_s2_reg && sel_s2_reg && !sel_s3_reg |=> an_restart
  ) else $error("Select pin toggle did not restart");

  partner_rf_a: assert property (
    partner_rf |=> bst_rf_reg && lpa_rf_reg && qst_rf_reg
  ) else $error("Partner fault bits not set");

  local_rf_a: assert property (
    local_link_fault |=> adv_remote_fault && lpa_rf_reg && ext_rf_reg
  ) else $error("Local fault not advertised");

  done_first_a: assert property (
    qst_read && !done_rpt_reg && prog_reg == anp_pkg::PROG_DONE
      |=> wb_dat_o[anp_pkg::QST_AN_BIT]
      && wb_dat_o[anp_pkg::QST_PROG_HI:anp_pkg::QST_PROG_LO] == 3'h7
  ) else $error("First read after completion did not return all ones");

  done_zero_a: assert property (
    qst_read && done_rpt_reg |=> wb_dat_o[anp_pkg::QST_AN_BIT]
      && wb_dat_o[anp_pkg::QST_PROG_HI:anp_pkg::QST_PROG_LO] == 3'h0
  ) else $error("Repeat read after completion did not return a zero code");

  pwrup_restart_a: assert property (
    pwrup_reg && en_eff |=> an_restart
  ) else $error("Power-up did not start negotiation");

  bus_ack_a: assert property (
    qst_rd_s |=> !wb_ack_o
  ) else $error("Ack held longer than one cycle");

endmodule // anp_autoneg_ctl

// >>> src/anp_pkg.sv
/*
  Constants for the auto-negotiation fault, restart and progress block:
  register indices, bit positions, reset values and progress codes.
  Assumes a 32-bit classic Wishbone bus with word-aligned registers.
*/
package anp_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [5:0] REG_CTL_IDX = 6'h00;
  localparam logic [5:0] REG_BST_IDX = 6'h01;
  localparam logic [5:0] REG_LPA_IDX = 6'h05;
  localparam logic [5:0] REG_QST_IDX = 6'h11;
  localparam logic [5:0] REG_EXT_IDX = 6'h13;

  // Control register fields
  localparam int CTL_SRST_BIT    = 15;
  localparam int CTL_AN_EN_BIT   = 12;
  localparam int CTL_RESTART_BIT = 9;

  // Basic status fields
  localparam int BST_AN_DONE_BIT = 5;
  localparam int BST_RF_BIT      = 4;
  localparam int BST_LINK_BIT    = 2;

  // Partner ability and extended control fields
  localparam int LPA_RF_BIT = 13;
  localparam int EXT_RF_BIT = 13;

  // Quick status fields
  localparam int QST_SPEED_BIT  = 15;
  localparam int QST_DUPLEX_BIT = 14;
  localparam int QST_PROG_HI    = 13;
  localparam int QST_PROG_LO    = 11;
  localparam int QST_AN_BIT     = 4;
  localparam int QST_RF_BIT     = 1;
  localparam int QST_LINK_BIT   = 0;

  // Reset values
  localparam logic       CTL_AN_EN_RST = 1'b1;
  localparam logic [3:0] PROG_RST      = 4'h0;

  // Progress codes
  localparam logic [3:0] PROG_MAX_NUM = 4'h8;
  localparam logic [3:0] PROG_DONE    = 4'hf;

endpackage

// >>> tb/anp_autoneg_ctl_bench.sv
/*
  Bench for the fault, restart and progress block.
  Assumes a one-wait-state Wishbone slave and the far-side model.
*/
`timescale 1ns/1ps
module anp_autoneg_ctl_bench;
  localparam logic [31:0] QM = 32'hffff_fffd;
  logic        ref_clk, resetn, cyc, stb, we, mode, asel, spd, dup, lnk, lf, rfq;
  logic        ack, an_en, an_rs, adv, ac, xa, prf;
  logic [3:0]  sel, tgt, arb, v, held;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat;
  logic [31:0] eq[$], mq[$];
  int          n_errors, checks, n_rs, rb, seed, cyc_n;

  anp_autoneg_ctl u_anp_autoneg_ctl (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_ack_o(ack), .wb_dat_o(rdat), .mode_pin_a(mode), .autoneg_select_pin(asel),
    .arb_state(arb), .an_complete(ac), .link_up(lnk), .speed_100(spd), .full_duplex(dup),
    .partner_rf(prf), .exchange_active(xa), .local_link_fault(lf), .an_enable(an_en),
    .an_restart(an_rs), .adv_remote_fault(adv));
  anp_far_model u_anp_far_model (.ref_clk(ref_clk), .resetn(resetn), .tgt(tgt),
    .rf_req(rfq), .an_restart(an_rs), .arb_state(arb), .an_complete(ac),
    .exchange_active(xa), .partner_rf(prf));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Reads leave their expected word in the queue for the monitor
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, m);
    int t;
    t = 0;
    if (!w) begin
      eq.push_back(d & m);
      mq.push_back(m);
    end
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; wdat <= w ? d : 32'h0;
    do @(posedge ref_clk); while (!ack && ++t < 50);
    if (t >= 50) n_errors++;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0; sel <= 4'h0;
    @(posedge ref_clk);
  endtask

  task automatic rs_chk(input int n);
    wt(10);
    chk(32'(n_rs - rb), 32'(n));
  endtask

  function automatic logic [31:0] q(input logic [3:0] p);
    return {16'h0, spd, dup, p[2:0], 6'h0, p[3], 3'h0, lnk};
  endfunction

  always @(posedge ref_clk) begin
    cyc_n++;
    if (an_rs) n_rs++;
    if (ack && !we && eq.size() > 0) chk(rdat & mq.pop_front(), eq.pop_front());
    if (cyc_n == 5000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    seed = 93074;
    {resetn, cyc, stb, we, lf, rfq} = '0;
    {mode, asel, lnk} = 3'b111;
    sel = 4'h0; tgt = 4'h0; adr = 8'h00; wdat = 32'h0;
    spd = 1'($random(seed));
    dup = 1'($random(seed));
    wt(16);
    resetn <= 1'b1;
    wt(2);
    wb(0, 8'h44, q(4'h0), QM);
    wb(0, 8'h00, 32'h1000, 32'h9200);
    wb(0, 8'h80, 32'h0, 32'hffff_ffff);
    $display("reset values done");
    // Random climb between reads; the held code only rises
    repeat (3) begin
      held = 4'h0;
      for (int i = 0; i < 6; i++) begin
        v = 4'($unsigned($random(seed)) % 9);
        tgt <= v;
        wt(3);
        if (v > held) held = v;
      end
      wb(0, 8'h44, q(held), QM);
      wb(0, 8'h44, q(v), QM);
      tgt <= 4'h0;
      wt(3);
      wb(0, 8'h44, q(v), QM);
      wb(0, 8'h44, q(4'h0), QM);
    end
    tgt <= 4'hf;
    wt(3);
    wb(0, 8'h04, 32'h24, 32'h24);
    wb(0, 8'h44, q(4'hf), QM);
    wb(0, 8'h44, q(4'h8), QM);
    tgt <= 4'h3;
    wt(3);
    wb(0, 8'h44, q(4'hf), QM);
    tgt <= 4'h5;
    wt(3);
    wb(0, 8'h44, q(4'h3), QM);
    $display("progress done");
    tgt <= 4'h0;
    rb = n_rs;
    wb(1, 8'h00, 32'h1200, 32'h0);
    rs_chk(1);
    wb(0, 8'h00, 32'h1000, 32'h1200);
    wb(0, 8'h44, q(4'h5), QM);
    wb(0, 8'h44, q(4'h0), QM);
    rb = n_rs;
    wb(1, 8'h00, 32'h0, 32'h0);
    wb(1, 8'h00, 32'h1000, 32'h0);
    rs_chk(1);
    rb = n_rs;
    lnk <= 1'b0;
    rs_chk(1);
    lnk <= 1'b1;
    mode <= 1'b0;
    wt(6);
    rb = n_rs;
    asel <= 1'b0;
    wt(6);
    chk({31'h0, an_en}, 32'h0);
    asel <= 1'b1;
    rs_chk(1);
    mode <= 1'b1;
    wt(6);
    $display("restart done");
    tgt <= 4'h2;
    rfq <= 1'b1;
    wt(3);
    rfq <= 1'b0;
    wb(0, 8'h04, 32'h10, 32'h10);
    wb(0, 8'h14, 32'h2000, 32'h2000);
    wb(0, 8'h4c, 32'h2000, 32'h2000);
    wb(0, 8'h44, 32'h2, 32'h2);
    wb(0, 8'h04, 32'h0, 32'h10);
    lf <= 1'b1;
    wt(2);
    chk({31'h0, adv}, 32'h1);
    lf <= 1'b0;
    wt(2);
    wb(0, 8'h14, 32'h2000, 32'h2000);
    wb(0, 8'h4c, 32'h2000, 32'h2000);
    $display("faults done");
    tgt <= 4'h6;
    wt(3);
    tgt <= 4'h0;
    wb(1, 8'h00, 32'h9000, 32'h0);
    wt(4);
    wb(0, 8'h44, q(4'h0), QM);
    $display("soft reset done");
    wt(4);
    wrap_up();
  end
endmodule // anp_autoneg_ctl_bench

// >>> tb/anp_far_model.sv
/*
  Far-side model: arbitration source and link partner code words.
  Assumes the bench picks the target arbitration state each cycle.
*/
`timescale 1ns/1ps
module anp_far_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Bench control
  input  wire logic [3:0] tgt,
  input  wire logic       rf_req,
  // Block side
  input  wire logic       an_restart,
  output logic      [3:0] arb_state,
  output logic            an_complete,
  output logic            exchange_active,
  output logic            partner_rf
);
  // Restart drops arbitration to idle for one cycle before it climbs again
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) arb_state <= 4'h0;
    else if (an_restart) arb_state <= 4'h0;
    else arb_state <= tgt;
  end
  assign an_complete     = arb_state == 4'hf;
  assign exchange_active = arb_state != 4'h0 && !an_complete;
  // Fault code rides only on code words of the exchange
  assign partner_rf      = rf_req && exchange_active;
endmodule // anp_far_model
